// ### common/cpu_ls_pkg.sv
// Shared constants and types for the load/store and bit-operation execution unit
// Functional notes
// (RQ1) Branch if overflow clear: one or two cycles
// (RQ2) Branch on interrupt flag set or clear
// (RQ3) Direct load takes three cycles
// (RQ4) Indirect load two cycles, pre-decrement or post-increment
// (RQ5) Displacement load from pointer plus offset
// (RQ6) Direct store takes two cycles
// (RQ7) Indirect store one cycle with pointer update
// (RQ8) Displacement store one cycle, pointer unchanged
// (RQ9) Program read through third pointer, three cycles
// (RQ10) I/O in and out take one cycle
// (RQ11) Push one cycle, pop two cycles
// (RQ12) Rotates move carry through bit ends
// (RQ13) Shifts fill zero or sign; left updates half-carry
// (RQ14) I/O bit set/clear, one cycle, flags untouched
// (RQ15) Register bit copied into transfer flag
// (RQ16) Transfer flag copied into register bit
// (RQ17) NVM-routed data access adds wait cycles
// (RQ18) Swap, copy, immediate, flag ops in one cycle
// (RQ19) Pointer updated exactly once per instruction
`default_nettype none
package cpu_ls_pkg;

  localparam int REG_COUNT = 32;

  // Register R0, pointer pair low registers and Z pointer select code
  localparam logic [4:0] REG_R0 = 5'h00;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [1:0] PTR_Z = 2'h2;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Cycle counts per operation class
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [2:0] CYC_LD_DIR = 3'h3;
  localparam logic [2:0] CYC_LD_IND = 3'h2;
  localparam logic [2:0] CYC_ST_DIR = 3'h2;
  localparam logic [2:0] CYC_PM_READ = 3'h3;
  localparam logic [2:0] CYC_POP = 3'h2;
  localparam logic [2:0] CYC_NVM_EXTRA = 3'h1;

  typedef enum logic [1:0] {
    PM_NONE = 2'h0,
    PM_POST_INC = 2'h1,
    PM_PRE_DEC = 2'h2
  } ptr_mode_e;

  typedef enum logic [4:0] {
    OP_NOP, OP_BR_NO_OVF, OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_MOV, OP_LDI,
    OP_LD_DIR, OP_LD_IND, OP_LD_DISP, OP_ST_DIR, OP_ST_IND, OP_ST_DISP,
    OP_PM_READ, OP_PM_READ_R0, OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP,
    OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP, OP_IO_BIT_SET,
    OP_IO_BIT_CLR, OP_BIT_TO_T, OP_T_TO_BIT, OP_FLAG_SET, OP_FLAG_CLR
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1
  } state_e;

endpackage
`default_nettype wire

// ### logic/ls_ptr_addr.sv
// Pointer address former with pre-decrement, post-increment and displacement
`timescale 1ns/1ns
`default_nettype none
module ls_ptr_addr (
  // Pointer and mode
  input wire logic [15:0] ptr_in,
  input wire cpu_ls_pkg::ptr_mode_e mode_in,
  input wire logic [5:0] disp_in,
  input wire logic use_disp_in,
  // Results
  output logic [15:0] addr_out,
  output logic [15:0] ptr_next_out
);

  logic [15:0] dec_val;
  logic [15:0] disp_val;

  assign dec_val = ptr_in - 16'h0001;
  assign disp_val = use_disp_in ? {10'h000, disp_in} : 16'h0000;

  always_comb
  begin
    addr_out = ptr_in + disp_val; // RQ5
    ptr_next_out = ptr_in;
    case (mode_in)
      cpu_ls_pkg::PM_PRE_DEC:
      begin
        addr_out = dec_val; // RQ19
        ptr_next_out = dec_val;
      end
      cpu_ls_pkg::PM_POST_INC:
      begin
        ptr_next_out = ptr_in + 16'h0001; // RQ19
      end
      default:
      begin
        ptr_next_out = ptr_in;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### logic/ls_shift_unit.sv
// Shift, rotate and nibble swap unit with flag results
`timescale 1ns/1ns
`default_nettype none
module ls_shift_unit (
  // Operation
  input wire cpu_ls_pkg::op_e op_in,
  input wire logic [7:0] val_in,
  input wire logic carry_in,
  // Results
  output logic [7:0] res_out,
  output logic [7:0] flags_out,
  output logic [7:0] mask_out
);

  always_comb
  begin
    logic c;
    logic h;
    logic upd;
    logic upd_h;
    c = 1'b0;
    h = val_in[3];
    upd = 1'b1;
    upd_h = 1'b0;
    res_out = val_in;
    case (op_in)
      cpu_ls_pkg::OP_LSL:
      begin
        res_out = {val_in[6:0], 1'b0}; // RQ13
        c = val_in[7];
        upd_h = 1'b1;
      end
      cpu_ls_pkg::OP_ROL:
      begin
        res_out = {val_in[6:0], carry_in}; // RQ12
        c = val_in[7];
        upd_h = 1'b1;
      end
      cpu_ls_pkg::OP_LSR:
      begin
        res_out = {1'b0, val_in[7:1]}; // RQ13
        c = val_in[0];
      end
      cpu_ls_pkg::OP_ROR:
      begin
        res_out = {carry_in, val_in[7:1]}; // RQ12
        c = val_in[0];
      end
      cpu_ls_pkg::OP_ASR:
      begin
        res_out = {val_in[7], val_in[7:1]}; // RQ13
        c = val_in[0];
      end
      cpu_ls_pkg::OP_SWAP:
      begin
        res_out = {val_in[3:0], val_in[7:4]}; // RQ18
        upd = 1'b0;
      end
      default:
      begin
        upd = 1'b0;
      end
    endcase
    flags_out = 8'h00;
    flags_out[cpu_ls_pkg::FLAG_C] = c;
    flags_out[cpu_ls_pkg::FLAG_Z] = (res_out == 8'h00);
    flags_out[cpu_ls_pkg::FLAG_N] = res_out[7];
    flags_out[cpu_ls_pkg::FLAG_V] = res_out[7] ^ c;
    flags_out[cpu_ls_pkg::FLAG_H] = h;
    mask_out = 8'h00;
    mask_out[cpu_ls_pkg::FLAG_C] = upd;
    mask_out[cpu_ls_pkg::FLAG_Z] = upd;
    mask_out[cpu_ls_pkg::FLAG_N] = upd;
    mask_out[cpu_ls_pkg::FLAG_V] = upd;
    mask_out[cpu_ls_pkg::FLAG_H] = upd_h; // RQ13
  end

endmodule
`default_nettype wire

// ### logic/ls_exec_core.sv
// Execution unit for branches, data transfers, shifts and bit operations
`timescale 1ns/1ns
`default_nettype none
module ls_exec_core #(
  parameter logic [15:0] NVM_BASE = 16'h1000,
  parameter logic [15:0] SP_INIT = 16'h0FFF
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Decoded operation
  input wire logic op_valid_in,
  input wire cpu_ls_pkg::op_e op_code_in,
  input wire logic [4:0] rd_in,
  input wire logic [4:0] rr_in,
  input wire logic [15:0] k_in,
  input wire logic [5:0] q_in,
  input wire logic [2:0] bit_in,
  input wire logic [1:0] ptr_sel_in,
  input wire cpu_ls_pkg::ptr_mode_e ptr_mode_in,
  output logic op_ready_out,
  // Core state
  output logic [15:0] pc_out,
  output logic [15:0] sp_out,
  output logic [7:0] status_flags_register_out,
  // Data space
  output logic [15:0] dmem_addr_out,
  output logic [7:0] dmem_wdata_out,
  output logic dmem_re_out,
  output logic dmem_we_out,
  input wire logic [7:0] dmem_rdata_in,
  input wire logic dmem_wait_in,
  // Program memory
  output logic [15:0] pmem_addr_out,
  output logic pmem_re_out,
  input wire logic [7:0] pmem_rdata_in,
  // I/O space
  output logic [5:0] io_addr_out,
  output logic [7:0] io_wdata_out,
  output logic io_re_out,
  output logic io_we_out,
  output logic io_bit_set_out,
  output logic io_bit_clr_out,
  output logic [2:0] io_bit_out,
  input wire logic [7:0] io_rdata_in
);

  logic [7:0] regs_ff [cpu_ls_pkg::REG_COUNT];
  logic [7:0] nxt_regs [cpu_ls_pkg::REG_COUNT];
  logic [7:0] view [cpu_ls_pkg::REG_COUNT];
  cpu_ls_pkg::state_e state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt;
  logic ready_ff, nxt_ready;
  logic [15:0] pc_ff, nxt_pc, sp_ff, nxt_sp;
  logic [7:0] status_flags_register_ff, nxt_status_flags_register;
  logic [15:0] dmem_addr_ff, nxt_dmem_addr, pmem_addr_ff, nxt_pmem_addr;
  logic [7:0] dmem_wdata_ff, nxt_dmem_wdata, io_wdata_ff, nxt_io_wdata;
  logic dmem_re_ff, nxt_dmem_re, dmem_we_ff, nxt_dmem_we, pmem_re_ff, nxt_pmem_re;
  logic [5:0] io_addr_ff, nxt_io_addr;
  logic io_re_ff, nxt_io_re, io_we_ff, nxt_io_we;
  logic io_set_ff, nxt_io_set, io_clr_ff, nxt_io_clr;
  logic [2:0] io_bit_ff, nxt_io_bit;
  logic ld_en_ff, nxt_ld_en, ld_pm_ff, nxt_ld_pm, io_pend_ff, nxt_io_pend;
  logic [4:0] ld_dst_ff, nxt_ld_dst, io_dst_ff, nxt_io_dst;
  logic [1:0] pa_sel;
  logic [4:0] ptr_lo, ptr_hi;
  logic [15:0] pa_ptr, pa_addr, pa_next;
  logic pa_disp;
  cpu_ls_pkg::ptr_mode_e pa_mode;
  logic [7:0] sh_res, sh_flags, sh_mask;
  logic rr_bit;

  // ************************************************************
  // Register view with pending I/O read merged in
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < cpu_ls_pkg::REG_COUNT; gi++)
    begin : g_view
      assign view[gi] = (io_pend_ff && io_dst_ff == 5'(gi)) ? io_rdata_in : regs_ff[gi]; // RQ10
    end
  endgenerate

  // ************************************************************
  // Operand selection and helper units
  // ************************************************************
  assign pa_sel = (op_code_in == cpu_ls_pkg::OP_PM_READ ||
                   op_code_in == cpu_ls_pkg::OP_PM_READ_R0) ? cpu_ls_pkg::PTR_Z : ptr_sel_in;
  assign ptr_lo = 5'(cpu_ls_pkg::PTR_X_LO + {2'h0, pa_sel, 1'b0});
  assign ptr_hi = 5'(ptr_lo + 5'h01);
  assign pa_ptr = {view[ptr_hi], view[ptr_lo]};
  assign pa_disp = (op_code_in == cpu_ls_pkg::OP_LD_DISP || op_code_in == cpu_ls_pkg::OP_ST_DISP);
  assign pa_mode = pa_disp ? cpu_ls_pkg::PM_NONE : ptr_mode_in; // RQ5 RQ8
  assign rr_bit = view[rr_in][bit_in];

  ls_ptr_addr u_ptr_addr (
    .ptr_in(pa_ptr),
    .mode_in(pa_mode),
    .disp_in(q_in),
    .use_disp_in(pa_disp),
    .addr_out(pa_addr),
    .ptr_next_out(pa_next)
  );

  ls_shift_unit u_shift (
    .op_in(op_code_in),
    .val_in(view[rd_in]),
    .carry_in(status_flags_register_ff[cpu_ls_pkg::FLAG_C]),
    .res_out(sh_res),
    .flags_out(sh_flags),
    .mask_out(sh_mask)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    logic br_take;
    logic ptr_wr;
    logic dacc;
    logic [2:0] cyc;
    logic [2:0] total;
    br_take = 1'b0;
    ptr_wr = 1'b0;
    dacc = 1'b0;
    cyc = cpu_ls_pkg::CYC_ONE;
    total = cpu_ls_pkg::CYC_ONE;
    nxt_regs = view;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_status_flags_register = status_flags_register_ff;
    nxt_dmem_addr = dmem_addr_ff;
    nxt_dmem_wdata = dmem_wdata_ff;
    nxt_dmem_re = 1'b0;
    nxt_dmem_we = 1'b0;
    nxt_pmem_addr = pmem_addr_ff;
    nxt_pmem_re = 1'b0;
    nxt_io_addr = io_addr_ff;
    nxt_io_wdata = io_wdata_ff;
    nxt_io_re = 1'b0;
    nxt_io_we = 1'b0;
    nxt_io_set = 1'b0;
    nxt_io_clr = 1'b0;
    nxt_io_bit = io_bit_ff;
    nxt_io_pend = 1'b0;
    nxt_io_dst = io_dst_ff;
    nxt_ld_en = ld_en_ff;
    nxt_ld_dst = ld_dst_ff;
    nxt_ld_pm = ld_pm_ff;
    case (state_ff)
      cpu_ls_pkg::ST_IDLE:
      begin
        if (op_valid_in)
        begin
          nxt_pc = pc_ff + 16'h0001;
          case (op_code_in)
            cpu_ls_pkg::OP_BR_NO_OVF: br_take = !status_flags_register_ff[cpu_ls_pkg::FLAG_V]; // RQ1
            cpu_ls_pkg::OP_BR_IRQ_ON: br_take = status_flags_register_ff[cpu_ls_pkg::FLAG_I]; // RQ2
            cpu_ls_pkg::OP_BR_IRQ_OFF: br_take = !status_flags_register_ff[cpu_ls_pkg::FLAG_I]; // RQ2
            cpu_ls_pkg::OP_MOV: nxt_regs[rd_in] = view[rr_in]; // RQ18
            cpu_ls_pkg::OP_LDI: nxt_regs[rd_in] = k_in[7:0]; // RQ18
            cpu_ls_pkg::OP_LD_DIR, cpu_ls_pkg::OP_LD_IND, cpu_ls_pkg::OP_LD_DISP, cpu_ls_pkg::OP_POP:
            begin
              dacc = 1'b1;
              nxt_dmem_re = 1'b1;
              nxt_ld_en = 1'b1;
              nxt_ld_pm = 1'b0;
              nxt_ld_dst = rd_in;
              nxt_dmem_addr = pa_addr; // RQ4 RQ5
              cyc = cpu_ls_pkg::CYC_LD_IND;
              ptr_wr = (op_code_in == cpu_ls_pkg::OP_LD_IND); // RQ4
              if (op_code_in == cpu_ls_pkg::OP_LD_DIR)
              begin
                nxt_dmem_addr = k_in; // RQ3
                cyc = cpu_ls_pkg::CYC_LD_DIR;
              end
              if (op_code_in == cpu_ls_pkg::OP_POP)
              begin
                nxt_sp = sp_ff + 16'h0001; // RQ11
                nxt_dmem_addr = nxt_sp;
                cyc = cpu_ls_pkg::CYC_POP;
              end
            end
            cpu_ls_pkg::OP_ST_DIR, cpu_ls_pkg::OP_ST_IND, cpu_ls_pkg::OP_ST_DISP, cpu_ls_pkg::OP_PUSH:
            begin
              dacc = 1'b1;
              nxt_dmem_we = 1'b1;
              nxt_dmem_wdata = view[rr_in];
              nxt_dmem_addr = pa_addr; // RQ7 RQ8
              ptr_wr = (op_code_in == cpu_ls_pkg::OP_ST_IND); // RQ7
              if (op_code_in == cpu_ls_pkg::OP_ST_DIR)
              begin
                nxt_dmem_addr = k_in; // RQ6
                cyc = cpu_ls_pkg::CYC_ST_DIR;
              end
              if (op_code_in == cpu_ls_pkg::OP_PUSH)
              begin
                nxt_dmem_addr = sp_ff; // RQ11
                nxt_sp = sp_ff - 16'h0001;
              end
            end
            cpu_ls_pkg::OP_PM_READ, cpu_ls_pkg::OP_PM_READ_R0:
            begin
              nxt_pmem_addr = pa_addr; // RQ9
              nxt_pmem_re = 1'b1;
              nxt_ld_en = 1'b1;
              nxt_ld_pm = 1'b1;
              nxt_ld_dst = (op_code_in == cpu_ls_pkg::OP_PM_READ) ? rd_in : cpu_ls_pkg::REG_R0;
              ptr_wr = (ptr_mode_in == cpu_ls_pkg::PM_POST_INC);
              cyc = cpu_ls_pkg::CYC_PM_READ;
            end
            cpu_ls_pkg::OP_IO_IN:
            begin
              nxt_io_addr = k_in[5:0]; // RQ10
              nxt_io_re = 1'b1;
              nxt_io_pend = 1'b1;
              nxt_io_dst = rd_in;
            end
            cpu_ls_pkg::OP_IO_OUT:
            begin
              nxt_io_addr = k_in[5:0]; // RQ10
              nxt_io_wdata = view[rr_in];
              nxt_io_we = 1'b1;
            end
            cpu_ls_pkg::OP_LSL, cpu_ls_pkg::OP_LSR, cpu_ls_pkg::OP_ROL, cpu_ls_pkg::OP_ROR,
            cpu_ls_pkg::OP_ASR, cpu_ls_pkg::OP_SWAP:
            begin
              nxt_regs[rd_in] = sh_res; // RQ12 RQ13
              nxt_status_flags_register = (status_flags_register_ff & ~sh_mask) | (sh_flags & sh_mask);
            end
            cpu_ls_pkg::OP_IO_BIT_SET, cpu_ls_pkg::OP_IO_BIT_CLR:
            begin
              nxt_io_addr = k_in[5:0]; // RQ14
              nxt_io_bit = bit_in;
              nxt_io_set = (op_code_in == cpu_ls_pkg::OP_IO_BIT_SET);
              nxt_io_clr = (op_code_in == cpu_ls_pkg::OP_IO_BIT_CLR);
            end
            cpu_ls_pkg::OP_BIT_TO_T: nxt_status_flags_register[cpu_ls_pkg::FLAG_T] = rr_bit; // RQ15
            cpu_ls_pkg::OP_T_TO_BIT: nxt_regs[rd_in][bit_in] = status_flags_register_ff[cpu_ls_pkg::FLAG_T]; // RQ16
            cpu_ls_pkg::OP_FLAG_SET: nxt_status_flags_register[bit_in] = 1'b1; // RQ18
            cpu_ls_pkg::OP_FLAG_CLR: nxt_status_flags_register[bit_in] = 1'b0; // RQ18
            default: nxt_pc = pc_ff + 16'h0001;
          endcase
          if (br_take)
          begin
            nxt_pc = pc_ff + k_in + 16'h0001; // RQ1 RQ2
            cyc = cpu_ls_pkg::CYC_BR_TAKEN;
          end
          if (ptr_wr)
          begin
            nxt_regs[ptr_lo] = pa_next[7:0]; // RQ19
            nxt_regs[ptr_hi] = pa_next[15:8];
          end
          total = cyc;
          if (dacc && nxt_dmem_addr >= NVM_BASE)
          begin
            total = 3'(cyc + cpu_ls_pkg::CYC_NVM_EXTRA); // RQ17
          end
          if (total > cpu_ls_pkg::CYC_ONE)
          begin
            nxt_state = cpu_ls_pkg::ST_WAIT;
            nxt_cnt = 3'(total - cpu_ls_pkg::CYC_ONE);
          end
          else
          begin
            nxt_ld_en = 1'b0;
          end
        end
      end
      cpu_ls_pkg::ST_WAIT:
      begin
        nxt_dmem_re = dmem_re_ff;
        nxt_dmem_we = dmem_we_ff;
        nxt_pmem_re = pmem_re_ff;
        if (cnt_ff > cpu_ls_pkg::CYC_ONE)
        begin
          nxt_cnt = 3'(cnt_ff - cpu_ls_pkg::CYC_ONE);
        end
        else if (!(dmem_wait_in && (dmem_re_ff || dmem_we_ff))) // RQ17
        begin
          if (ld_en_ff)
          begin
            nxt_regs[ld_dst_ff] = ld_pm_ff ? pmem_rdata_in : dmem_rdata_in;
          end
          nxt_ld_en = 1'b0;
          nxt_dmem_re = 1'b0;
          nxt_dmem_we = 1'b0;
          nxt_pmem_re = 1'b0;
          nxt_state = cpu_ls_pkg::ST_IDLE;
        end
      end
      default: nxt_state = cpu_ls_pkg::ST_IDLE;
    endcase
    nxt_ready = (nxt_state == cpu_ls_pkg::ST_IDLE);
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      regs_ff <= '{default: 8'h00};
      state_ff <= cpu_ls_pkg::ST_IDLE;
      cnt_ff <= 3'h0;
      ready_ff <= 1'b1;
      pc_ff <= 16'h0000;
      sp_ff <= SP_INIT;
      status_flags_register_ff <= 8'h00;
      dmem_addr_ff <= 16'h0000;
      dmem_wdata_ff <= 8'h00;
      dmem_re_ff <= 1'b0;
      dmem_we_ff <= 1'b0;
      pmem_addr_ff <= 16'h0000;
      pmem_re_ff <= 1'b0;
      io_addr_ff <= 6'h00;
      io_wdata_ff <= 8'h00;
      io_re_ff <= 1'b0;
      io_we_ff <= 1'b0;
      io_set_ff <= 1'b0;
      io_clr_ff <= 1'b0;
      io_bit_ff <= 3'h0;
      io_pend_ff <= 1'b0;
      io_dst_ff <= 5'h00;
      ld_en_ff <= 1'b0;
      ld_pm_ff <= 1'b0;
      ld_dst_ff <= 5'h00;
    end
    else
    begin
      regs_ff <= nxt_regs;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_ready;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      status_flags_register_ff <= nxt_status_flags_register;
      dmem_addr_ff <= nxt_dmem_addr;
      dmem_wdata_ff <= nxt_dmem_wdata;
      dmem_re_ff <= nxt_dmem_re;
      dmem_we_ff <= nxt_dmem_we;
      pmem_addr_ff <= nxt_pmem_addr;
      pmem_re_ff <= nxt_pmem_re;
      io_addr_ff <= nxt_io_addr;
      io_wdata_ff <= nxt_io_wdata;
      io_re_ff <= nxt_io_re;
      io_we_ff <= nxt_io_we;
      io_set_ff <= nxt_io_set;
      io_clr_ff <= nxt_io_clr;
      io_bit_ff <= nxt_io_bit;
      io_pend_ff <= nxt_io_pend;
      io_dst_ff <= nxt_io_dst;
      ld_en_ff <= nxt_ld_en;
      ld_pm_ff <= nxt_ld_pm;
      ld_dst_ff <= nxt_ld_dst;
    end
  end

  assign op_ready_out = ready_ff;
  assign pc_out = pc_ff;
  assign sp_out = sp_ff;
  assign status_flags_register_out = status_flags_register_ff;
  assign dmem_addr_out = dmem_addr_ff;
  assign dmem_wdata_out = dmem_wdata_ff;
  assign dmem_re_out = dmem_re_ff;
  assign dmem_we_out = dmem_we_ff;
  assign pmem_addr_out = pmem_addr_ff;
  assign pmem_re_out = pmem_re_ff;
  assign io_addr_out = io_addr_ff;
  assign io_wdata_out = io_wdata_ff;
  assign io_re_out = io_re_ff;
  assign io_we_out = io_we_ff;
  assign io_bit_set_out = io_set_ff;
  assign io_bit_clr_out = io_clr_ff;
  assign io_bit_out = io_bit_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic acc;
  logic [15:0] x_pair;
  assign acc = op_valid_in && ready_ff;
  assign x_pair = {regs_ff[cpu_ls_pkg::PTR_X_LO + 5'h01], regs_ff[cpu_ls_pkg::PTR_X_LO]};

  a_br_ovf_taken: assert property (acc && op_code_in == cpu_ls_pkg::OP_BR_NO_OVF && !status_flags_register_ff[3] |=> !op_ready_out ##1 op_ready_out) else $error("taken branch not two cycles"); // RQ1
  a_br_ovf_skip: assert property (acc && op_code_in == cpu_ls_pkg::OP_BR_NO_OVF && status_flags_register_ff[3] |=> op_ready_out && pc_out == $past(pc_ff) + 16'h0001) else $error("untaken branch wrong"); // RQ1
  a_br_irq_target: assert property (acc && op_code_in == cpu_ls_pkg::OP_BR_IRQ_ON && status_flags_register_ff[7] |=> pc_out == $past(pc_ff) + $past(k_in) + 16'h0001) else $error("irq branch target wrong"); // RQ2
  a_ld_dir_len: assert property (acc && op_code_in == cpu_ls_pkg::OP_LD_DIR |=> !op_ready_out ##1 !op_ready_out) else $error("direct load too short"); // RQ3
  a_ld_ptr_inc: assert property (acc && op_code_in == cpu_ls_pkg::OP_LD_IND && ptr_sel_in == 2'h0 && ptr_mode_in == cpu_ls_pkg::PM_POST_INC |=> x_pair == $past(pa_ptr) + 16'h0001) else $error("post increment wrong"); // RQ4
  a_st_ind_one: assert property (acc && op_code_in == cpu_ls_pkg::OP_ST_IND && pa_addr < NVM_BASE && ptr_mode_in != cpu_ls_pkg::PM_PRE_DEC |=> dmem_we_out && op_ready_out ##1 !dmem_we_out || op_ready_out) else $error("indirect store not one cycle"); // RQ7
  a_st_disp_keep: assert property (acc && op_code_in == cpu_ls_pkg::OP_ST_DISP && ptr_sel_in == 2'h0 |=> x_pair == $past(pa_ptr)) else $error("displacement store moved pointer"); // RQ8
  a_pm_len: assert property (acc && op_code_in == cpu_ls_pkg::OP_PM_READ |=> pmem_re_out [*2] ##1 op_ready_out && !pmem_re_out) else $error("program read not three cycles"); // RQ9
  a_io_bit_flags: assert property (acc && op_code_in == cpu_ls_pkg::OP_IO_BIT_SET |=> io_bit_set_out && status_flags_register_out == $past(status_flags_register_ff) && op_ready_out) else $error("io bit set wrong"); // RQ14
  a_bit_to_t: assert property (acc && op_code_in == cpu_ls_pkg::OP_BIT_TO_T |=> status_flags_register_out[6] == $past(rr_bit)) else $error("transfer flag wrong"); // RQ15
  a_nvm_extra: assert property (acc && op_code_in == cpu_ls_pkg::OP_ST_DIR && k_in >= NVM_BASE |=> !op_ready_out [*2]) else $error("nvm store lacks extra cycle"); // RQ17

  c_branch_taken: cover property (acc && op_code_in == cpu_ls_pkg::OP_BR_IRQ_OFF && !status_flags_register_ff[7]);
  c_pop_done: cover property (acc && op_code_in == cpu_ls_pkg::OP_POP ##2 op_ready_out);
  c_nvm_wait: cover property (state_ff == cpu_ls_pkg::ST_WAIT && dmem_wait_in && dmem_we_ff);

endmodule
`default_nettype wire

// ### test/ls_mem_model.sv
// Behavioural data, program and I/O space behind the execution unit
`timescale 1ns/1ns
`default_nettype none
module ls_mem_model (
  // Clock
  input wire logic sys_clk_in,
  // Data space
  input wire logic [15:0] dmem_addr_in,
  input wire logic [7:0] dmem_wdata_in,
  input wire logic dmem_re_in,
  input wire logic dmem_we_in,
  output logic [7:0] dmem_rdata_out,
  // Program memory
  input wire logic [15:0] pmem_addr_in,
  input wire logic pmem_re_in,
  output logic [7:0] pmem_rdata_out,
  // I/O space
  input wire logic [5:0] io_addr_in,
  input wire logic io_re_in,
  output logic [7:0] io_rdata_out
);
  logic [7:0] dmem [0:255];
  logic [7:0] toggle_ff = 8'h5a;
  always_ff @(posedge sys_clk_in)
  begin
    toggle_ff <= ~toggle_ff;
    if (dmem_we_in)
    begin
      dmem[dmem_addr_in[7:0]] <= dmem_wdata_in;
    end
  end
  // Unselected buses show a changing pattern
  assign dmem_rdata_out = dmem_re_in ? dmem[dmem_addr_in[7:0]] : toggle_ff;
  assign pmem_rdata_out = pmem_re_in ? (pmem_addr_in[7:0] ^ 8'h3c) : toggle_ff;
  assign io_rdata_out = io_re_in ? {2'h0, io_addr_in} : ~toggle_ff;
endmodule
`default_nettype wire

// ### test/ls_exec_core_bench.sv
// Self-checking bench for the load/store and bit-operation unit
`timescale 1ns/1ns
`default_nettype none
module ls_exec_core_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  cpu_ls_pkg::op_e opc = cpu_ls_pkg::OP_NOP;
  logic [4:0] rd = 5'h00;
  logic [15:0] k = 16'h0000;
  logic [15:0] p;
  logic [2:0] bsel = 3'h0;
  cpu_ls_pkg::ptr_mode_e pm = cpu_ls_pkg::PM_NONE;
  logic rdy, dre, dwe, pre, ire;
  logic [15:0] pc, da, pa, sp;
  logic [7:0] status_flags_register, wd, rdd, rdp, rdio;
  logic [5:0] ia;
  int mismatches = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  ls_exec_core ls_exec_core_i (.sys_clk_in(clk), .rst_n_in(rst_n), .op_valid_in(vld),
    .op_code_in(opc), .rd_in(rd), .rr_in(rd), .k_in(k), .q_in(6'h00), .bit_in(bsel),
    .ptr_sel_in(2'h0), .ptr_mode_in(pm), .op_ready_out(rdy), .pc_out(pc), .sp_out(sp),
    .status_flags_register_out(status_flags_register), .dmem_addr_out(da), .dmem_wdata_out(wd), .dmem_re_out(dre),
    .dmem_we_out(dwe), .dmem_rdata_in(rdd), .dmem_wait_in(1'b0), .pmem_addr_out(pa),
    .pmem_re_out(pre), .pmem_rdata_in(rdp), .io_addr_out(ia), .io_wdata_out(),
    .io_re_out(ire), .io_we_out(), .io_bit_set_out(), .io_bit_clr_out(), .io_bit_out(),
    .io_rdata_in(rdio));
  ls_mem_model ls_mem_model_i (.sys_clk_in(clk), .dmem_addr_in(da), .dmem_wdata_in(wd),
    .dmem_re_in(dre), .dmem_we_in(dwe), .dmem_rdata_out(rdd), .pmem_addr_in(pa),
    .pmem_re_in(pre), .pmem_rdata_out(rdp), .io_addr_in(ia), .io_re_in(ire),
    .io_rdata_out(rdio));
  // ************
  // Tasks
  // ************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Issue one op, count cycles until ready again
  task automatic op_chk(input cpu_ls_pkg::op_e c, input logic [4:0] d,
      input logic [15:0] kk, input int exp);
    int n;
    n = 1;
    @(negedge clk);
    vld = 1'b1;
    opc = c;
    rd = d;
    k = kk;
    @(negedge clk);
    vld = 1'b0;
    while (rdy !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20)
    begin
      mismatches++;
      stop_test();
    end
    check(n, exp);
  endtask
  task automatic st_chk(input logic [4:0] d, input logic [7:0] a, input logic [7:0] exp);
    op_chk(cpu_ls_pkg::OP_ST_DIR, d, {8'h00, a}, 2);
    check(ls_mem_model_i.dmem[a], exp);
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_direct();
    op_chk(cpu_ls_pkg::OP_LDI, 5'h10, 16'h0081, 1);
    st_chk(5'h10, 8'h40, 8'h81);
    op_chk(cpu_ls_pkg::OP_LD_DIR, 5'h11, 16'h0040, 3);
    st_chk(5'h11, 8'h41, 8'h81);
    op_chk(cpu_ls_pkg::OP_LD_DIR, 5'h12, 16'h1000, 4);
  endtask
  task automatic t_shift();
    op_chk(cpu_ls_pkg::OP_LSL, 5'h10, 16'h0000, 1);
    check(status_flags_register[0], 1'b1);
    op_chk(cpu_ls_pkg::OP_ROR, 5'h10, 16'h0000, 1);
    check(status_flags_register[0], 1'b0);
    st_chk(5'h10, 8'h42, 8'h81);
  endtask
  task automatic t_branch();
    bsel = 3'h3;
    op_chk(cpu_ls_pkg::OP_FLAG_CLR, 5'h00, 16'h0000, 1);
    check(status_flags_register[3], 1'b0);
    p = pc;
    op_chk(cpu_ls_pkg::OP_BR_NO_OVF, 5'h00, 16'h0005, 2);
    check(pc, p + 16'h0006);
    op_chk(cpu_ls_pkg::OP_BR_IRQ_ON, 5'h00, 16'h0005, 1);
    bsel = 3'h7;
    op_chk(cpu_ls_pkg::OP_FLAG_SET, 5'h00, 16'h0000, 1);
    op_chk(cpu_ls_pkg::OP_BR_IRQ_OFF, 5'h00, 16'hfffe, 1);
    p = pc;
    op_chk(cpu_ls_pkg::OP_BR_IRQ_ON, 5'h00, 16'hfffe, 2);
    check(pc, p - 16'h0001);
  endtask
  task automatic t_bits();
    op_chk(cpu_ls_pkg::OP_BIT_TO_T, 5'h10, 16'h0000, 1);
    check(status_flags_register[6], 1'b1);
    bsel = 3'h2;
    op_chk(cpu_ls_pkg::OP_T_TO_BIT, 5'h13, 16'h0000, 1);
    st_chk(5'h13, 8'h43, 8'h04);
  endtask
  task automatic t_pointer();
    op_chk(cpu_ls_pkg::OP_LDI, 5'h1a, 16'h0050, 1);
    pm = cpu_ls_pkg::PM_POST_INC;
    op_chk(cpu_ls_pkg::OP_ST_IND, 5'h10, 16'h0000, 1);
    // One-cycle store lands at the next edge
    @(negedge clk);
    check(ls_mem_model_i.dmem[8'h50], 8'h81);
    pm = cpu_ls_pkg::PM_PRE_DEC;
    op_chk(cpu_ls_pkg::OP_LD_IND, 5'h14, 16'h0000, 2);
    pm = cpu_ls_pkg::PM_NONE;
    st_chk(5'h14, 8'h44, 8'h81);
    op_chk(cpu_ls_pkg::OP_ST_IND, 5'h13, 16'h0000, 1);
    @(negedge clk);
    check(ls_mem_model_i.dmem[8'h50], 8'h04);
    op_chk(cpu_ls_pkg::OP_PM_READ_R0, 5'h00, 16'h0000, 3);
    st_chk(5'h00, 8'h45, 8'h3c);
  endtask
  task automatic t_stack();
    op_chk(cpu_ls_pkg::OP_PUSH, 5'h10, 16'h0000, 1);
    check(sp, 16'h0ffe);
    op_chk(cpu_ls_pkg::OP_POP, 5'h15, 16'h0000, 2);
    check(sp, 16'h0fff);
    st_chk(5'h15, 8'h46, 8'h81);
    op_chk(cpu_ls_pkg::OP_IO_IN, 5'h16, 16'h0015, 1);
    st_chk(5'h16, 8'h47, 8'h15);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_direct();
    t_shift();
    t_branch();
    t_bits();
    t_pointer();
    t_stack();
    stop_test();
  end
endmodule
`default_nettype wire
